// ### dicb_device.sv
/*
  Converter input clocking and bus-mode logic: clock mode decode, synthesizer
  divider control, power-down, loop-filter reset and input port routing.
  Assumes the source keeps its own rules; ports sampled through two flops.
*/
// What this block does
// - Sync dual mode: FIFO cleared whenever it holds data and no write is presented
// - Sync dual mode needs sync select, enable
// - Dual clock mode: FIFO is elastic buffer
// - Dual mode synchronised by separate control input
// - Differential or single-ended rate clock selection
// - External mode: drive rate clock pin out
// - Synth mode: sample clock is reference
// - Reference divided by 1, 2, 4, 8
// - Feedback divided by 1 to 32
// - Reference over 160 MHz needs divisor
// - Optional oscillator divide-by-two
// - Synth unused: disable and sleep
// - Loop filter reset toggle resets control
// - Mode 00: independent ports per channel
// - Modes 01/10: deinterleave from one port
// - Transmit gate rising edge marks A
// - Unused port top bit flags A/B
// - Mode 11: half-rate pair, first port to A, second port to B
`timescale 1ns/1ps
module dicb_device
  import dicb_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  dicb_link_if.device      link,
  input  wire logic        sync_dual_clock_select_in,
  input  wire logic        rate_clock_input_enable_in,
  input  wire logic        rate_clock_comp_input_enable_in,
  input  wire logic        differential_rate_clock_enable_in,
  input  wire logic        synth_enable_in,
  input  wire logic        synth_sleep_in,
  input  wire logic [2:0]  ref_divider_sel_in,
  input  wire logic [4:0]  feedback_divider_sel_in,
  input  wire logic        osc_half_divider_in,
  input  wire logic        loop_filter_reset_in,
  input  wire logic [1:0]  input_bus_select_in,
  input  wire logic        first_sample_flag_select_in,
  input  wire logic        sample_ready_in,
  output logic [15:0]      chan_a_out,
  output logic [15:0]      chan_b_out,
  output logic             chan_valid_out,
  output logic [4:0]       clock_mode_out,
  output logic             unsupported_out,
  output logic             diff_clock_out,
  output logic [5:0]       ref_divisor_out,
  output logic [5:0]       fb_divisor_out,
  output logic             osc_div2_out,
  output logic             synth_power_out,
  output logic             loop_reset_out,
  output logic             fifo_full_out,
  output logic             rate_clock_oe_n_out,
  output logic             rate_clock_out
);
  typedef struct packed {
    logic [15:0] pa1, pa2, pb1, pb2;
    logic        tg1, tg2, tg3, sy1, sy2, lr1, lr2, lr3;
    logic        have_a;
    logic [15:0] hold;
    logic [15:0] chan_a, chan_b;
    logic        chan_valid;
    logic [4:0]  mode;
    logic        unsup, diffc, osc2, pwr, lreset, full, oe_n, rclk;
    logic [5:0]  refd, fbd;
    logic [$clog2(DICB_RATE_DIV)-1:0] rdiv;
  } dicb_dev_t;

  dicb_dev_t st, next_st;
  logic [31:0] f_wdata, f_rdata;
  logic        f_wvalid, f_wready, f_rvalid, f_flush;
  logic        pair_done;
  logic [15:0] pair_a, pair_b;

  dicb_fifo #(.WIDTH(32), .DEPTH(DICB_FIFO_DEPTH)) u_fifo (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .flush_in     (f_flush),
    .wr_data_in   (f_wdata),
    .wr_valid_in  (f_wvalid),
    .wr_ready_out (f_wready),
    .rd_data_out  (f_rdata),
    .rd_valid_out (f_rvalid),
    .rd_ready_in  (sample_ready_in)
  );

  always_comb begin
    next_st     = st;
    pair_done   = 1'b0;
    pair_a      = st.pa2;
    pair_b      = st.pb2;
    // Pins cross through two flops before use
    next_st.pa1 = link.first_input_port;
    next_st.pa2 = st.pa1;
    next_st.pb1 = link.second_input_port;
    next_st.pb2 = st.pb1;
    next_st.tg1 = link.transmit_gate;
    next_st.tg2 = st.tg1;
    next_st.tg3 = st.tg2;
    next_st.sy1 = link.sync_in;
    next_st.sy2 = st.sy1;
    next_st.lr1 = loop_filter_reset_in;
    next_st.lr2 = st.lr1;
    next_st.lr3 = st.lr2;

    if (sync_dual_clock_select_in && rate_clock_input_enable_in && !synth_enable_in) begin
      next_st.mode = DICB_CM_SYNC;
    end else if (sync_dual_clock_select_in) begin
      next_st.mode = DICB_CM_BAD;
    end else if (synth_enable_in) begin
      next_st.mode = DICB_CM_SYNTH;
    end else if (rate_clock_input_enable_in) begin
      next_st.mode = DICB_CM_DUAL;
    end else begin
      next_st.mode = DICB_CM_EXT;
    end
    next_st.unsup = (next_st.mode == DICB_CM_BAD) ||
                    (differential_rate_clock_enable_in && !rate_clock_input_enable_in);
    next_st.diffc = differential_rate_clock_enable_in && rate_clock_comp_input_enable_in;

    case (ref_divider_sel_in)
      3'h0:    next_st.refd = 6'h01;
      3'h1:    next_st.refd = 6'h02;
      3'h2:    next_st.refd = 6'h04;
      default: next_st.refd = 6'h08;
    endcase
    case (feedback_divider_sel_in)
      5'h00:   next_st.fbd = 6'h01;
      5'h01:   next_st.fbd = 6'h02;
      5'h02:   next_st.fbd = 6'h04;
      5'h03:   next_st.fbd = 6'h08;
      5'h04:   next_st.fbd = 6'h10;
      default: next_st.fbd = 6'h20;
    endcase
    next_st.osc2 = osc_half_divider_in && synth_enable_in;
    next_st.pwr  = synth_enable_in && !synth_sleep_in;
    // Edge of reset toggle clears control
    next_st.lreset = (st.lr2 != st.lr3) || !next_st.pwr;
    // Loop runs whenever synth is enabled and not asleep, whatever the mode; detector lives in analog domain

    // Rate clock output in external mode
    next_st.oe_n = !(st.mode == DICB_CM_EXT || (st.mode == DICB_CM_SYNTH &&
                     !rate_clock_input_enable_in));
    next_st.rdiv = st.rdiv + 1'b1;
    if (st.rdiv == '1) begin
      next_st.rclk = !st.rclk;
    end

    // Input routing
    case (input_bus_select_in)
      DICB_BUS_DUAL: pair_done = 1'b1;
      DICB_BUS_ILV_A, DICB_BUS_ILV_B: begin
        if (first_sample_flag_select_in) begin
          if (st.tg2 && !st.tg3) begin
            next_st.have_a = 1'b1;
            next_st.hold   = (input_bus_select_in == DICB_BUS_ILV_A) ? st.pa2 : st.pb2;
          end else if (st.have_a) begin
            pair_done      = 1'b1;
            next_st.have_a = 1'b0;
          end
        end else begin
          // Top bit of unused port flags A
          if (((input_bus_select_in == DICB_BUS_ILV_A) ? st.pb2[DICB_FLAG_BIT]
                                                       : st.pa2[DICB_FLAG_BIT])) begin
            next_st.have_a = 1'b1;
            next_st.hold   = (input_bus_select_in == DICB_BUS_ILV_A) ? st.pa2 : st.pb2;
          end else if (st.have_a) begin
            pair_done      = 1'b1;
            next_st.have_a = 1'b0;
          end
        end
        pair_a = st.hold;
        pair_b = (input_bus_select_in == DICB_BUS_ILV_A) ? st.pa2 : st.pb2;
      end
      DICB_BUS_HALF: begin
        pair_done = 1'b1;
        pair_a    = st.pa2;
        pair_b    = st.pb2;
      end
      default: pair_done = 1'b0;
    endcase

    // Output stage; channel B carries second half-rate sample in mode 11
    next_st.chan_valid = f_rvalid && sample_ready_in;
    if (f_rvalid && sample_ready_in) begin
      next_st.chan_a = f_rdata[31:16];
      next_st.chan_b = f_rdata[15:0];
    end
    next_st.full = !f_wready;

    if (rst_in) begin
      next_st = '0;
      next_st.oe_n = 1'b1;
    end
  end

  // Sync mode clears FIFO whenever it holds data and no write is presented; in dual mode the sync input realigns it
  assign f_flush  = (st.mode == DICB_CM_SYNC) ? f_rvalid && !f_wvalid
                                              : (st.mode == DICB_CM_DUAL && st.sy2);
  assign f_wvalid = pair_done && (st.mode != DICB_CM_BAD) && (st.mode != 5'h00);
  assign f_wdata  = {pair_a, pair_b};

  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end

  assign chan_a_out          = st.chan_a;
  assign chan_b_out          = st.chan_b;
  assign chan_valid_out      = st.chan_valid;
  assign clock_mode_out      = st.mode;
  assign unsupported_out     = st.unsup;
  assign diff_clock_out      = st.diffc;
  assign ref_divisor_out     = st.refd;
  assign fb_divisor_out      = st.fbd;
  assign osc_div2_out        = st.osc2;
  assign synth_power_out     = st.pwr;
  assign loop_reset_out      = st.lreset;
  assign fifo_full_out       = st.full;
  assign rate_clock_oe_n_out = st.oe_n;
  assign rate_clock_out      = st.rclk;
  assign link.dev_rate_clock      = st.rclk;
  assign link.dev_rate_clock_oe_n = st.oe_n;
endmodule : dicb_device

// ### dicb_pkg.sv
/*
  Shared constants and types for the converter input clocking and bus block.
  Assumes one clock domain (mclk_in, 25 MHz) shared by both ends.
*/
package dicb_pkg;
  localparam int unsigned DICB_DW          = 16;
  localparam int unsigned DICB_FIFO_DEPTH  = 4;
  localparam logic [1:0]  DICB_BUS_DUAL    = 2'h0;
  localparam logic [1:0]  DICB_BUS_ILV_A   = 2'h1;
  localparam logic [1:0]  DICB_BUS_ILV_B   = 2'h2;
  localparam logic [1:0]  DICB_BUS_HALF    = 2'h3;
  localparam logic [2:0]  DICB_REFDIV_RST  = 3'h0;
  localparam logic [4:0]  DICB_FBDIV_RST   = 5'h0;
  localparam int unsigned DICB_FLAG_BIT    = 15;
  localparam int unsigned DICB_RATE_DIV    = 2;

  typedef enum logic [4:0] {
    DICB_CM_SYNC  = 5'h01,
    DICB_CM_DUAL  = 5'h02,
    DICB_CM_EXT   = 5'h04,
    DICB_CM_SYNTH = 5'h08,
    DICB_CM_BAD   = 5'h10
  } dicb_clkmode_t;
endpackage : dicb_pkg

// ### dicb_link_if.sv
/*
  Link between the data source and the converter input logic.
  Assumes both ends share mclk_in; rate clock pin resolved here from enables.
*/
`timescale 1ns/1ps
interface dicb_link_if;
  logic [15:0] first_input_port;
  logic [15:0] second_input_port;
  logic        transmit_gate;
  logic        sync_in;
  logic        src_rate_clock;
  logic        src_rate_clock_oe_n;
  logic        dev_rate_clock;
  logic        dev_rate_clock_oe_n;
  logic        rate_clock_pin;

  assign rate_clock_pin = !dev_rate_clock_oe_n ? dev_rate_clock :
                          !src_rate_clock_oe_n ? src_rate_clock : 1'b0;

  modport device (input first_input_port, second_input_port, transmit_gate, sync_in,
                  rate_clock_pin, output dev_rate_clock, dev_rate_clock_oe_n);
  modport source (output first_input_port, second_input_port, transmit_gate, sync_in,
                  src_rate_clock, src_rate_clock_oe_n, input rate_clock_pin);
endinterface : dicb_link_if

// ### dicb_fifo.sv
/*
  Small flop FIFO with valid/ready on both sides.
  Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module dicb_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             flush_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } dicb_fifo_t;

  dicb_fifo_t st, next_st;
  logic       do_wr;
  logic       do_rd;

  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;
  // Count is one bit wider than the pointers so that full differs from empty
  assign wr_ready_out = (st.cnt != (AW+1)'(DEPTH)) && !rst_in;
  assign rd_valid_out = (st.cnt != '0);
  assign rd_data_out  = st.mem[st.rp];

  always_comb begin
    next_st = st;
    if (do_wr) begin
      next_st.mem[st.wp] = wr_data_in;
      next_st.wp         = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
    end
    if (do_rd) begin
      next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    // Flush wins over a write in the same cycle; storage itself is not cleared
    if (rst_in || flush_in) begin
      next_st.wp  = '0;
      next_st.rp  = '0;
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end
endmodule : dicb_fifo

// ### dicb_source.sv
/*
  Data source end: drives the two input ports, gate, sync and A/B flag.
  Assumes the device samples ports on mclk_in through two flops.
*/
`timescale 1ns/1ps
module dicb_source
  import dicb_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  dicb_link_if.source      link,
  input  wire logic [1:0]  input_bus_select_in,
  input  wire logic        first_sample_flag_select_in,
  input  wire logic        gate_in,
  input  wire logic        sync_req_in,
  input  wire logic [15:0] data_a_in,
  input  wire logic [15:0] data_b_in,
  output logic             take_out
);
  typedef struct packed {
    logic [15:0] pa, pb;
    logic        tg, sy, phase, take;
  } dicb_src_t;

  dicb_src_t st, next_st;

  always_comb begin
    next_st = st;
    next_st.sy = sync_req_in;
    next_st.tg = gate_in;
    next_st.take = 1'b0;
    if (input_bus_select_in == DICB_BUS_ILV_A || input_bus_select_in == DICB_BUS_ILV_B) begin
      next_st.phase = gate_in ? !st.phase : 1'b0;
      next_st.take  = gate_in && st.phase;
      if (input_bus_select_in == DICB_BUS_ILV_A) begin
        next_st.pa = next_st.phase ? data_a_in : data_b_in;
        // Toggle top bit of unused port unless first_sample_flag_select_in is set
        next_st.pb = {next_st.phase && !first_sample_flag_select_in, 15'h0000};
      end else begin
        next_st.pb = next_st.phase ? data_a_in : data_b_in;
        next_st.pa = {next_st.phase && !first_sample_flag_select_in, 15'h0000};
      end
    end else begin
      next_st.pa   = data_a_in;
      next_st.pb   = data_b_in;
      next_st.take = gate_in;
    end
    if (rst_in) begin
      next_st = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    st <= next_st;
  end

  assign link.first_input_port    = st.pa;
  assign link.second_input_port   = st.pb;
  assign link.transmit_gate       = st.tg;
  assign link.sync_in             = st.sy;
  assign link.src_rate_clock      = 1'b0;
  assign link.src_rate_clock_oe_n = 1'b1;
  assign take_out                 = st.take;
endmodule : dicb_source

// ### dicb_link_properties.sv
/*
  Checker on the source-device link signals.
  Assumes one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module dicb_link_properties (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] first_input_port,
  input  wire logic [15:0] second_input_port,
  input  wire logic        transmit_gate,
  input  wire logic        sync_in,
  input  wire logic        src_rate_clock_oe_n,
  input  wire logic        dev_rate_clock,
  input  wire logic        dev_rate_clock_oe_n,
  input  wire logic        rate_clock_pin
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  // Three cycles of the device driving the pin
  sequence drv3;
    !dev_rate_clock_oe_n [*3];
  endsequence
  sequence rise_drv;
    $rose(dev_rate_clock) ##0 drv3;
  endsequence
  sequence fall_drv;
    $fell(dev_rate_clock) ##0 drv3;
  endsequence

  AST_PIN_FOLLOWS: assert property (!dev_rate_clock_oe_n |-> rate_clock_pin == dev_rate_clock)
    else $error("rate clock pin differs from device clock");
  AST_RATE_HIGH_TWO: assert property (rise_drv |-> $fell(dev_rate_clock))
    else $error("rate clock high phase not two cycles");
  AST_RATE_LOW_TWO: assert property (fall_drv |-> $rose(dev_rate_clock))
    else $error("rate clock low phase not two cycles");
  AST_SRC_PIN_OFF: assert property (src_rate_clock_oe_n)
    else $error("source drives the rate clock pin");
  AST_PIN_IDLE_LOW: assert property (dev_rate_clock_oe_n && src_rate_clock_oe_n |-> !rate_clock_pin)
    else $error("released rate clock pin not low");
  AST_PIN_RESET_OFF: assert property ($fell(rst_in) |-> dev_rate_clock_oe_n)
    else $error("pin driven straight after reset");
  AST_PORTS_RESET_CLEAR: assert property ($fell(rst_in) |->
    first_input_port == 16'h0000 && second_input_port == 16'h0000)
    else $error("input ports not clear after reset");
  AST_GATE_RESET_LOW: assert property ($fell(rst_in) |-> !transmit_gate && !sync_in)
    else $error("gate or sync high after reset");
endmodule : dicb_link_properties

// ### tb.sv
/*
  Self-checking bench: source and device joined by the link.
  Assumes both ends share mclk_in and a synchronous reset.
*/
`timescale 1ns/1ps
module tb;
  import dicb_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        sel, en, comp, dif, syn, slp, osc, lf_rst, flag, rdy, gate, sync_req;
  logic [2:0]  ref_sel;
  logic [4:0]  fb_sel;
  logic [1:0]  bus;
  logic [15:0] data_a, data_b, chan_a_out, chan_b_out, pa, pb, exp_cnt;
  logic [4:0]  clock_mode_out;
  logic [5:0]  ref_divisor_out, fb_divisor_out;
  logic        chan_valid_out, unsupported_out, diff_clock_out, osc_div2_out, synth_power_out;
  logic        loop_reset_out, fifo_full_out, rate_clock_oe_n_out, rate_clock_out, take_out;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          cnt;
  logic [2:0]  cm_set [7] = '{3'b010, 3'b110, 3'b000, 3'b011, 3'b001, 3'b111, 3'b100};
  logic [4:0]  cm_exp [7] = '{5'h02, 5'h01, 5'h04, 5'h08, 5'h08, 5'h10, 5'h10};
  logic [1:0]  bm [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  logic        fl [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  dicb_link_if i_dicb_link_if ();
  dicb_device i_dicb_device (.mclk_in(mclk_in), .rst_in(rst_in), .link(i_dicb_link_if),
    .sync_dual_clock_select_in(sel), .rate_clock_input_enable_in(en),
    .rate_clock_comp_input_enable_in(comp), .differential_rate_clock_enable_in(dif),
    .synth_enable_in(syn), .synth_sleep_in(slp), .ref_divider_sel_in(ref_sel),
    .feedback_divider_sel_in(fb_sel), .osc_half_divider_in(osc), .loop_filter_reset_in(lf_rst),
    .input_bus_select_in(bus), .first_sample_flag_select_in(flag), .sample_ready_in(rdy),
    .chan_a_out(chan_a_out), .chan_b_out(chan_b_out), .chan_valid_out(chan_valid_out),
    .clock_mode_out(clock_mode_out), .unsupported_out(unsupported_out),
    .diff_clock_out(diff_clock_out), .ref_divisor_out(ref_divisor_out),
    .fb_divisor_out(fb_divisor_out), .osc_div2_out(osc_div2_out),
    .synth_power_out(synth_power_out), .loop_reset_out(loop_reset_out),
    .fifo_full_out(fifo_full_out), .rate_clock_oe_n_out(rate_clock_oe_n_out),
    .rate_clock_out(rate_clock_out));
  dicb_source i_dicb_source (.mclk_in(mclk_in), .rst_in(rst_in), .link(i_dicb_link_if),
    .input_bus_select_in(bus), .first_sample_flag_select_in(flag), .gate_in(gate),
    .sync_req_in(sync_req), .data_a_in(data_a), .data_b_in(data_b), .take_out(take_out));
  dicb_link_properties u_props (.mclk_in(mclk_in), .rst_in(rst_in),
    .first_input_port(i_dicb_link_if.first_input_port),
    .second_input_port(i_dicb_link_if.second_input_port),
    .transmit_gate(i_dicb_link_if.transmit_gate), .sync_in(i_dicb_link_if.sync_in),
    .src_rate_clock_oe_n(i_dicb_link_if.src_rate_clock_oe_n),
    .dev_rate_clock(i_dicb_link_if.dev_rate_clock),
    .dev_rate_clock_oe_n(i_dicb_link_if.dev_rate_clock_oe_n),
    .rate_clock_pin(i_dicb_link_if.rate_clock_pin));

  always #20 mclk_in = ~mclk_in;

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : tick

  // Gate held until the source reports the pair taken
  task automatic send(input logic [15:0] a, input logic [15:0] b);
    int n = 0;
    data_a = a;
    data_b = b;
    gate = 1'b1;
    do begin
      tick(1);
      n++;
    end while (take_out !== 1'b1 && n < 20);
    gate = 1'b0;
    tick(1);
  endtask : send

  // Hold new port data, then flush through the sync input so no stale word remains
  task automatic settle(input logic [15:0] a, input logic [15:0] b);
    data_a = a;
    data_b = b;
    tick(4);
    sync_req = 1'b1;
    tick(1);
    sync_req = 1'b0;
    tick(5);
  endtask : settle

  task automatic drain(output int c, output logic [15:0] a, output logic [15:0] b);
    c = 0;
    rdy = 1'b1;
    repeat (30) begin
      tick(1);
      if (chan_valid_out === 1'b1) begin
        if (c == 0) {a, b} = {chan_a_out, chan_b_out};
        c++;
      end
    end
    rdy = 1'b0;
  endtask : drain

  initial begin
    {sel, en, comp, dif, syn, slp, osc, lf_rst, flag, rdy, gate, sync_req} = 12'h208;
    {ref_sel, fb_sel, bus, data_a, data_b} = '0;
    tick(16);
    rst_in = 1'b0;
    tick(2);
    for (int i = 0; i < 7; i++) begin
      {sel, en, syn} = cm_set[i];
      tick(8);
      check("clock_mode", 16'(clock_mode_out), 16'(cm_exp[i]));
      check("unsupported", 16'(unsupported_out), 16'(cm_exp[i] == 5'h10));
      if (cm_exp[i] != 5'h10) check("rate_oe_n", 16'(rate_clock_oe_n_out), 16'(en));
    end
    for (int d = 0; d < 3; d++) begin
      {dif, comp} = 2'(d + 1);
      tick(2);
      check("diff_clock", 16'(diff_clock_out), 16'(d == 2));
    end
    $display("test clock modes done");
    {sel, en, syn, slp} = 4'b0110;
    for (int i = 0; i < 6; i++) begin
      ref_sel = 3'(i & 3);
      fb_sel = 5'(i);
      osc = i[0];
      tick(2);
      check("ref_divisor", 16'(ref_divisor_out), 16'(1 << (i & 3)));
      check("fb_divisor", 16'(fb_divisor_out), 16'(1 << i));
      check("osc_div2", 16'(osc_div2_out), 16'(i & 1));
    end
    check("synth_power", 16'(synth_power_out), 16'h0001);
    lf_rst = 1'b1;
    cnt = 0;
    repeat (8) begin
      tick(1);
      if (loop_reset_out === 1'b1) cnt++;
    end
    check("loop_reset_seen", 16'(cnt > 0), 16'h0001);
    check("loop_reset_end", 16'(loop_reset_out), 16'h0000);
    {syn, slp} = 2'b01;
    tick(2);
    check("synth_power", 16'(synth_power_out), 16'h0000);
    $display("test synthesizer done");
    // Dual clock mode, every bus mode and flag kind
    for (int i = 0; i < 6; i++) begin
      bus = bm[i];
      flag = fl[i];
      settle(16'h9a00 + 16'(i), 16'h2b00 + 16'(i));
      send(16'h9a00 + 16'(i), 16'h2b00 + 16'(i));
      drain(cnt, pa, pb);
      // Modes 00 and 11 take a word every cycle, so a ready sink pops one each cycle
      exp_cnt = (bm[i] == DICB_BUS_DUAL || bm[i] == DICB_BUS_HALF) ? 16'h001e : 16'h0001;
      check("pair_count", 16'(cnt), exp_cnt);
      check("chan_a", pa, 16'h9a00 + 16'(i));
      check("chan_b", pb, 16'h2b00 + 16'(i));
    end
    bus = DICB_BUS_DUAL;
    settle(16'h5555, 16'haaaa);
    sel = 1'b1;
    tick(4);
    send(16'h5555, 16'haaaa);
    drain(cnt, pa, pb);
    check("sync_count", 16'(cnt), 16'h001e);
    check("sync_chan_a", pa, 16'h5555);
    check("sync_chan_b", pb, 16'haaaa);
    $display("test bus modes done");
    // One pair per send in interleaved mode, so the fill level is known
    sel = 1'b0;
    bus = DICB_BUS_ILV_A;
    flag = 1'b1;
    settle(16'h0000, 16'h0000);
    for (int k = 0; k < 6; k++) send(16'h0c00 + 16'(k), 16'h0d00 + 16'(k));
    tick(6);
    check("fifo_full", 16'(fifo_full_out), 16'h0001);
    drain(cnt, pa, pb);
    check("fifo_count", 16'(cnt), 16'(DICB_FIFO_DEPTH));
    check("fifo_first", pa, 16'h0c00);
    check("fifo_first_b", pb, 16'h0d00);
    send(16'h0e00, 16'h0f00);
    tick(6);
    sync_req = 1'b1;
    tick(1);
    sync_req = 1'b0;
    tick(4);
    drain(cnt, pa, pb);
    check("flushed_count", 16'(cnt), 16'h0000);
    $display("test buffering done");
    close_out();
  end
endmodule : tb
